// *** rtl/adc_conversion_scan_control.sv ***
// Conversion, shutdown, output enable and scan control of the converter
`timescale 1ns/100ps
`include "adc_scan_consts.svh"
module adc_conversion_scan_control
    import adc_scan_pkg::*;
#(
    parameter int RESULT_WIDTH = `RESULT_BITS,
    parameter int CONV_CYCLES = `CONV_CYCLES,
    parameter int ACQ_CYCLES = `ACQ_CYCLES,
    parameter int NAP_WAKE_CYCLES = `NAP_WAKE_CYCLES,
    parameter int SLEEP_WAKE_CYCLES = `SLEEP_WAKE_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Processor strobes
    input wire logic conversion_start_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic power_down_n,
    // Mode and configuration pins
    input wire logic mode_select_hi,
    input wire logic mode_select_lo,
    input wire logic [`ADDR_BITS-1:0] mux_address_in,
    input wire logic differential_select,
    input wire logic gain_range_select,
    input wire logic polarity_select,
    // Raw offset-binary code from the converter core
    input wire logic [RESULT_WIDTH-1:0] core_code,
    // Status
    output logic busy_n,
    output logic nap_mode,
    output logic sleep_mode,
    // Parallel data pins
    output logic [RESULT_WIDTH+`TAG_BITS-1:0] data_out,
    output logic data_oe,
    output logic [`ADDR_BITS-1:0] mux_address_out,
    output logic differential_flag_out,
    // Analog front-end steering
    output logic [`ADDR_BITS-1:0] mux_select,
    output logic mux_differential,
    output logic mux_gain,
    output logic track_enable,
    // Result stream
    output logic result_valid,
    input wire logic result_ready,
    output logic [RESULT_WIDTH+`TAG_BITS-1:0] result_word
);

    localparam int WW = RESULT_WIDTH + `TAG_BITS;
    localparam int TW = $clog2(SLEEP_WAKE_CYCLES + CONV_CYCLES + 1);

    // ============================================================
    // State
    ctrl_state_type state;
    ctrl_state_type next_state;
    logic [TW-1:0] timer;
    logic [TW-1:0] next_timer;
    logic start_prev;
    logic mode_lo_prev;
    logic sleep_chosen;
    logic [`ADDR_BITS-1:0] scan_count;
    logic [`ADDR_BITS-1:0] next_scan_count;
    logic [`ADDR_BITS-1:0] held_addr;
    logic held_differential_select;
    logic held_gain;
    logic held_pol;
    logic cur_pol;
    logic [WW-1:0] next_word;

    // ============================================================
    // Decoding
    wire scan_mode = ~mode_select_hi & mode_select_lo;
    wire direct_mode = ~mode_select_hi & ~mode_select_lo;
    wire sequencer_mode = mode_select_hi;
    wire start_fall = start_prev & ~conversion_start_n;
    wire in_shutdown = ~power_down_n;
    wire timer_done = (timer == '0);
    wire buf_ready;
    wire mode_lo_changed = mode_lo_prev ^ mode_select_lo;

    wire [`ADDR_BITS-1:0] eff_addr = write_n ? held_addr : mux_address_in;
    wire eff_differential_select = write_n ? held_differential_select : differential_select;
    wire eff_gain = write_n ? held_gain : gain_range_select;
    wire eff_pol = write_n ? held_pol : polarity_select;

    wire [`ADDR_BITS-1:0] scan_addr =
        eff_differential_select ? {scan_count[`ADDR_BITS-1:1], 1'b0} : scan_count;

    wire [`ADDR_BITS-1:0] conv_addr = scan_mode ? scan_addr : eff_addr;

    // only accepted from the ready state
    // Sequencer modes are not built here, so their starts are refused
    wire start_ok = start_fall & ~chip_select_n & ~sequencer_mode &
        (state == st_ready);

    wire finish_push = (state == st_finish) & buf_ready;

    // bipolar flips the sign bit of the offset-binary code
    function automatic logic [RESULT_WIDTH-1:0] code_format(
        input logic [RESULT_WIDTH-1:0] code,
        input logic bipolar
    );
        code_format = code;
        if (bipolar)
            code_format[RESULT_WIDTH-1] = ~code[RESULT_WIDTH-1];
    endfunction : code_format

    // tag is differential flag then address, above the result
    assign next_word = {mux_differential, mux_select,
        code_format(core_code, cur_pol)};

    // ============================================================
    // Next state
    always_comb
    begin
        next_state = state;
        next_timer = timer;
        if (in_shutdown)
        begin
            // shutdown overrides everything, even a running conversion
            next_state = st_shutdown;
            next_timer = '0;
        end
        else
        begin
            unique case (state)
                st_ready:
                begin
                    if (start_ok)
                    begin
                        next_state = st_convert;
                        next_timer = TW'(CONV_CYCLES - 1);
                    end
                end
                st_convert:
                begin
                    if (timer_done)
                        next_state = st_finish;
                    else
                        next_timer = timer - 1'b1;
                end
                st_finish:
                begin
                    // A full buffer holds busy low rather than drop a word
                    if (buf_ready)
                    begin
                        // acquisition window before the next start
                        next_state = st_acquire;
                        next_timer = TW'(ACQ_CYCLES - 1);
                    end
                end
                st_acquire:
                begin
                    if (timer_done)
                        next_state = st_ready;
                    else
                        next_timer = timer - 1'b1;
                end
                st_shutdown:
                begin
                    // sleep or nap wake time, picked by sleep_chosen, for the reference to settle
                    next_state = st_wake;
                    next_timer = sleep_chosen ?
                        TW'(SLEEP_WAKE_CYCLES - 1) : TW'(NAP_WAKE_CYCLES - 1);
                end
                st_wake:
                begin
                    if (timer_done)
                        next_state = st_ready;
                    else
                        next_timer = timer - 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            state <= st_ready;
            timer <= '0;
        end
        else
        begin
            state <= next_state;
            timer <= next_timer;
        end
    end

    // ============================================================
    // Edge history
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            start_prev <= 1'b1;
            mode_lo_prev <= 1'b0;
        end
        else
        begin
            start_prev <= conversion_start_n;
            mode_lo_prev <= mode_select_lo;
        end
    end

    // ============================================================
    // Shutdown type
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            sleep_chosen <= 1'b0;
            nap_mode <= 1'b0;
            sleep_mode <= 1'b0;
        end
        else
        begin
            // chip select level chooses nap or sleep
            if (in_shutdown)
                sleep_chosen <= chip_select_n;
            nap_mode <= in_shutdown & ~chip_select_n;
            sleep_mode <= in_shutdown & chip_select_n;
        end
    end

    // ============================================================
    // Configuration hold
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            held_addr <= `ADDR_RESET;
            held_differential_select <= 1'b0;
            held_gain <= 1'b0;
            held_pol <= 1'b0;
        end
        // follow pins while write low, keep while high
        else if (!write_n)
        begin
            held_addr <= mux_address_in;
            held_differential_select <= differential_select;
            held_gain <= gain_range_select;
            held_pol <= polarity_select;
        end
    end

    // ============================================================
    // Scan counter
    always_comb
    begin
        next_scan_count = scan_count;
        // any change of the low mode input clears the count
        if (mode_lo_changed)
            next_scan_count = `ADDR_RESET;
        // step by two for a pair, by one otherwise
        else if (finish_push && scan_mode)
            next_scan_count = mux_select +
                (mux_differential ? `DIFFERENTIAL_SELECT_STEP : `SINGLE_STEP);
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            scan_count <= `ADDR_RESET;
        else
            scan_count <= next_scan_count;
    end

    // ============================================================
    // Per-conversion setup
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            mux_select <= `ADDR_RESET;
            mux_differential <= 1'b0;
            mux_gain <= 1'b0;
            cur_pol <= 1'b0;
        end
        // differential level taken fresh at each start
        else if (start_ok)
        begin
            mux_select <= conv_addr;
            mux_differential <= eff_differential_select;
            mux_gain <= eff_gain;
            cur_pol <= eff_pol;
        end
    end

    // ============================================================
    // Busy and track
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            busy_n <= 1'b1;
            track_enable <= 1'b1;
        end
        else
        begin
            // busy low from start until the result is stored
            busy_n <= ~(next_state == st_convert ||
                next_state == st_finish);
            track_enable <= (next_state == st_ready ||
                next_state == st_acquire);
        end
    end

    // ============================================================
    // Output word and pin drivers
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            data_out <= `WORD_RESET;
            mux_address_out <= `ADDR_RESET;
            differential_flag_out <= 1'b0;
        end
        // old word stays until the new one lands with busy rising
        // a read during conversion still returns the previous word
        // address of this conversion presented with its result
        else if (finish_push)
        begin
            data_out <= next_word;
            mux_address_out <= mux_select;
            differential_flag_out <= mux_differential;
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            data_oe <= 1'b0;
        // drivers on only while read and select are low
        // both held low keep the drivers on continuously
        // drivers stay off until read and select are both low, whichever falls last
        else
            data_oe <= ~read_n & ~chip_select_n;
    end

    // ============================================================
    // Result stream
    result_buffer #(
        .WIDTH(WW),
        .DEPTH(`BUFFER_DEPTH)
    ) u_result_buffer (
        .clock(clock),
        .sys_rst(sys_rst),
        .in_valid(state == st_finish),
        .in_ready(buf_ready),
        .in_data(next_word),
        .out_valid(result_valid),
        .out_ready(result_ready),
        .out_data(result_word)
    );

    // Direct mode needs no logic of its own beyond the address select
    wire unused_direct = direct_mode;

endmodule : adc_conversion_scan_control

// *** rtl/adc_scan_consts.svh ***
// Timing counts, field positions and reset values of the scan controller
`ifndef ADC_SCAN_CONSTS_SVH
`define ADC_SCAN_CONSTS_SVH

// ============================================================
// Clock
`define CLK_PERIOD_NS 50

// ============================================================
// Conversion and acquisition times
`define CONV_TYP_NS 550
`define CONV_MAX_NS 650
`define CONV_CYCLES (`CONV_MAX_NS / `CLK_PERIOD_NS)
`define ACQ_MAX_NS 150
`define ACQ_CYCLES (`ACQ_MAX_NS / `CLK_PERIOD_NS)
`define THROUGHPUT_NS 800

// ============================================================
// Wake-up times
`define NAP_WAKE_NS 200
`define NAP_WAKE_CYCLES (`NAP_WAKE_NS / `CLK_PERIOD_NS)
`define SLEEP_WAKE_MS 10
`define SLEEP_WAKE_CYCLES (`SLEEP_WAKE_MS * 1000000 / `CLK_PERIOD_NS)

// ============================================================
// Output word layout
`define RESULT_BITS 12
`define TAG_BITS 4
`define WORD_BITS 16
`define ADDR_BITS 3
`define DIFFERENTIAL_SELECT_STEP 3'h2
`define SINGLE_STEP 3'h1
`define ADDR_RESET 3'h0
`define WORD_RESET 16'h0000
`define BUFFER_DEPTH 2

`endif

// *** rtl/adc_scan_pkg.sv ***
// Types shared by the scan controller files
package adc_scan_pkg;

    // ============================================================
    // Controller states
    typedef enum logic [2:0] {
        st_ready,
        st_convert,
        st_finish,
        st_acquire,
        st_shutdown,
        st_wake
    } ctrl_state_type;

endpackage : adc_scan_pkg

// *** rtl/result_buffer.sv ***
// Two-entry shift buffer with valid and ready on both sides
`timescale 1ns/100ps
module result_buffer
    import adc_scan_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = 2
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] entry [DEPTH];
    logic [DEPTH-1:0] full;
    logic [CW-1:0] count;
    logic [CW-1:0] after_pop;
    logic [CW-1:0] next_count;
    wire pop = out_ready & full[0];
    wire push = in_valid & in_ready;

    // Head always sits in entry 0, so the output needs no read mux
    assign in_ready = ~full[DEPTH-1];
    assign out_valid = full[0];
    assign out_data = entry[0];
    assign after_pop = count - CW'(pop);
    assign next_count = after_pop + CW'(push);

    always_ff @(posedge clock)
    begin
        if (sys_rst)
            count <= '0;
        else
            count <= next_count;
    end

    // ============================================================
    // Storage
    generate
        for (genvar i = 0; i < DEPTH; i++)
        begin : g_entry
            always_ff @(posedge clock)
            begin
                if (sys_rst)
                    full[i] <= 1'b0;
                else
                    full[i] <= (CW'(i) < next_count);
            end
            always_ff @(posedge clock)
            begin
                if (push && after_pop == CW'(i))
                    entry[i] <= in_data;
                else if (pop && i + 1 < DEPTH)
                    entry[i] <= entry[(i + 1) % DEPTH];
            end
        end
    endgenerate

endmodule : result_buffer

// *** bench/adc_scan_checker_properties.sv ***
// Port-level assertions for the conversion and scan controller
`timescale 1ns/100ps
`include "adc_scan_consts.svh"
module adc_scan_checker
#(
    parameter int RESULT_WIDTH = 12
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Strobes and pins
    input wire logic conversion_start_n,
    input wire logic chip_select_n,
    input wire logic read_n,
    input wire logic write_n,
    input wire logic power_down_n,
    input wire logic mode_select_lo,
    input wire logic [`ADDR_BITS-1:0] mux_address_in,
    // Outputs
    input wire logic busy_n,
    input wire logic sleep_mode,
    input wire logic [RESULT_WIDTH+`TAG_BITS-1:0] data_out,
    input wire logic data_oe,
    input wire logic [`ADDR_BITS-1:0] mux_address_out,
    input wire logic [`ADDR_BITS-1:0] mux_select,
    input wire logic mux_differential,
    input wire logic track_enable,
    input wire logic result_valid,
    input wire logic result_ready,
    input wire logic [RESULT_WIDTH+`TAG_BITS-1:0] result_word
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ============================================================
    // Output enable and status
    AST_OE_FOLLOWS: assert property (!$past(sys_rst) |->
        data_oe == $past(!read_n && !chip_select_n))
        else $error("data_oe does not follow read and select");
    AST_SLEEP_SEL: assert property (!$past(sys_rst) |->
        sleep_mode == $past(!power_down_n && chip_select_n))
        else $error("sleep_mode wrong for select level");
    AST_TRACK_OFF: assert property (!busy_n |-> !track_enable)
        else $error("tracking while converting");
    // ============================================================
    // Start and busy timing
    AST_START_CAUSE: assert property ($fell(busy_n) |->
        ($past(conversion_start_n, 2) || $past(sys_rst, 2)) &&
        !$past(conversion_start_n) && !$past(chip_select_n))
        else $error("conversion began without a selected fall");
    AST_BUSY_HOLD: assert property ($fell(busy_n) |->
        (!busy_n || !power_down_n)[*8])
        else $error("busy released too early");
    AST_ACQ_GAP: assert property ($rose(busy_n) && !$past(sys_rst) |->
        busy_n[*4])
        else $error("new conversion inside acquisition");
    // ============================================================
    // Addressing and output word
    AST_DIRECT_MUX: assert property ($fell(busy_n) &&
        !$past(mode_select_lo) && !$past(write_n) |->
        mux_select == $past(mux_address_in))
        else $error("direct address not applied");
    AST_PAIR_EVEN: assert property ($fell(busy_n) &&
        $past(mode_select_lo) && mux_differential |-> !mux_select[0])
        else $error("differential scan on odd address");
    AST_TAG_MATCH: assert property ($rose(busy_n) &&
        $past(power_down_n) && !$past(sys_rst) |->
        data_out[15] == mux_differential &&
        data_out[14:12] == mux_select && mux_address_out == mux_select)
        else $error("channel tag differs from converted address");
    AST_WORD_HELD: assert property (result_valid && !result_ready |=>
        result_valid && $stable(result_word))
        else $error("stalled word lost or changed");
endmodule : adc_scan_checker

bind adc_conversion_scan_control adc_scan_checker
    #(.RESULT_WIDTH(RESULT_WIDTH)) u_checker (.clock(clock),
    .sys_rst(sys_rst), .conversion_start_n(conversion_start_n),
    .chip_select_n(chip_select_n), .read_n(read_n), .write_n(write_n),
    .power_down_n(power_down_n), .mode_select_lo(mode_select_lo),
    .mux_address_in(mux_address_in), .busy_n(busy_n),
    .sleep_mode(sleep_mode), .data_out(data_out), .data_oe(data_oe),
    .mux_address_out(mux_address_out), .mux_select(mux_select),
    .mux_differential(mux_differential), .track_enable(track_enable),
    .result_valid(result_valid), .result_ready(result_ready),
    .result_word(result_word));

// *** bench/stream_sink_model.sv ***
// Processor-side receiver of the result stream
`timescale 1ns/100ps
module stream_sink_model
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Stall request from the bench
    input wire logic stall,
    // Result stream
    output logic result_ready
);
    // ============================================================
    // drive ready from the stall request
    // Ready moves only on edges, so a stall always spans whole cycles
    always_ff @(posedge clock)
    begin
        result_ready <= !sys_rst && !stall;
    end
endmodule : stream_sink_model

// *** bench/adc_conversion_scan_control_tb_top.sv ***
// Self-checking bench of the conversion and scan controller
`timescale 1ns/100ps
module adc_conversion_scan_control_tb_top;
    logic clock, sys_rst, conversion_start_n, chip_select_n, read_n;
    logic write_n, power_down_n, mode_select_hi, mode_select_lo;
    logic differential_select, gain_range_select, polarity_select;
    logic busy_n, nap_mode, sleep_mode, data_oe, differential_flag_out;
    logic mux_differential, mux_gain, track_enable, result_valid;
    logic result_ready, stall;
    logic [2:0] mux_address_in, mux_address_out, mux_select, cnt;
    logic [11:0] core_code;
    logic [15:0] data_out, result_word, last;
    logic [15:0] exp_q[$];
    logic [31:0] rng;
    int errors, cmp_count;

    adc_conversion_scan_control #(.SLEEP_WAKE_CYCLES(20)) dut (.clock,
        .sys_rst, .conversion_start_n, .chip_select_n, .read_n, .write_n,
        .power_down_n, .mode_select_hi, .mode_select_lo, .mux_address_in,
        .differential_select, .gain_range_select, .polarity_select,
        .core_code, .busy_n, .nap_mode, .sleep_mode, .data_out, .data_oe,
        .mux_address_out, .differential_flag_out, .mux_select,
        .mux_differential, .mux_gain, .track_enable, .result_valid,
        .result_ready, .result_word);
    stream_sink_model sink (.clock, .sys_rst, .stall, .result_ready);

    // ============================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            errors++;
            $display("BAD %0t: saw %h wanted %h", $time, seen, want);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #5;
    endtask : cyc
    task automatic wait_busy(input logic lvl);
        for (int k = 0; k < 100 && busy_n !== lvl; k++)
            cyc(1);
    endtask : wait_busy
    task automatic test_done();
        if (errors == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    // ============================================================
    // One conversion; kind 1 refires, 2 slow memory, 3 ROM read
    // Pins show the inverse while write is high, so held values count
    task automatic convert(input logic [2:0] a, input logic d,
                           input logic p, input int kind);
        logic [2:0] ea;
        logic [15:0] w;
        logic g;
        rng = xs(rng);
        core_code = rng[11:0];
        mux_address_in = write_n ? ~a : a;
        differential_select = write_n ? ~d : d;
        polarity_select = write_n ? ~p : p;
        g = write_n ? gain_range_select : rng[12];
        gain_range_select = write_n ? ~g : g;
        ea = mode_select_lo ? (d ? {cnt[2:1], 1'b0} : cnt) : a;
        cnt = ea + (d ? 3'h2 : 3'h1);
        w = {d, ea, core_code ^ {p, 11'h000}};
        exp_q.push_back(w);
        conversion_start_n = 0;
        read_n = (kind < 2);
        cyc(3);
        // start high early or after busy
        if (kind != 2)
            conversion_start_n = 1;
        if (kind >= 2)
            check(data_out, last);
        if (kind == 3)
            read_n = 1;
        if (kind == 1)
        begin
            cyc(2);
            conversion_start_n = 0;
            cyc(2);
            conversion_start_n = 1;
        end
        wait_busy(1);
        check(data_out, w);
        check({differential_flag_out, mux_address_out}, {d, ea});
        check(mux_gain, g);
        conversion_start_n = 1;
        read_n = 1;
        last = w;
        cyc(4);
    endtask : convert

    // ============================================================
    // Watcher pairs each streamed word with the oldest note
    always @(posedge clock)
        if (!sys_rst && result_valid === 1'b1 && result_ready === 1'b1)
            check(result_word,
                exp_q.size() ? exp_q.pop_front() : 16'hXXXX);

    initial
    begin
        clock = 0;
        forever #25 clock = ~clock;
    end
    initial
    begin
        cyc(20000);
        errors++;
        test_done();
    end

    initial
    begin
        {sys_rst, conversion_start_n, read_n, power_down_n} = 4'hF;
        {chip_select_n, write_n, mode_select_hi, mode_select_lo} = 4'h0;
        {differential_select, gain_range_select, polarity_select} = 3'h0;
        {mux_address_in, core_code, stall, cnt, last} = 0;
        rng = 32'h85A2;
        errors = 0;
        cmp_count = 0;
        repeat (2) @(posedge clock);
        #5 sys_rst = 0;
        cyc(1);
        for (int i = 0; i < 8; i++)
            convert(i[2:0], 1'b0, i[0], i % 4);
        check(data_oe, 0);
        read_n = 0;
        cyc(2);
        check(data_oe, 1);
        check(data_out, last);
        chip_select_n = 1;
        cyc(2);
        check(data_oe, 0);
        {chip_select_n, read_n} = 2'h1;
        mux_address_in = 3'h5;
        polarity_select = 1;
        cyc(1);
        write_n = 1;
        convert(3'h5, 1'b0, 1'b1, 0);
        write_n = 0;
        // scan from zero, random pair steps
        mode_select_lo = 1;
        cnt = 0;
        cyc(2);
        for (int i = 0; i < 14; i++)
        begin
            rng = xs(rng);
            if (i == 9)
            begin
                mode_select_lo = 0;
                cyc(2);
                mode_select_lo = 1;
                cnt = 0;
                cyc(2);
            end
            convert(rng[2:0], rng[3], rng[4], 0);
        end
        // Fill the buffer with the reader stalled
        stall = 1;
        convert(3'h1, 1'b1, 1'b0, 0);
        convert(3'h2, 1'b0, 1'b0, 0);
        fork
            convert(3'h3, 1'b0, 1'b1, 0);
            begin
                cyc(40);
                check(busy_n, 0);
                stall = 0;
            end
        join
        mode_select_lo = 0;
        // Sleep, then nap with a refused start
        chip_select_n = 1;
        power_down_n = 0;
        cyc(3);
        check(sleep_mode, 1);
        power_down_n = 1;
        cyc(30);
        chip_select_n = 0;
        convert(3'h6, 1'b0, 1'b0, 0);
        power_down_n = 0;
        cyc(3);
        check(nap_mode, 1);
        conversion_start_n = 0;
        cyc(3);
        check(busy_n, 1);
        conversion_start_n = 1;
        power_down_n = 1;
        cyc(6);
        convert(3'h7, 1'b0, 1'b1, 0);
        // Sequencer modes are not built, so a start there is refused
        mode_select_hi = 1;
        conversion_start_n = 0;
        cyc(3);
        check(busy_n, 1);
        {mode_select_hi, conversion_start_n} = 2'h1;
        cyc(10);
        check(16'(exp_q.size()), 0);
        test_done();
    end
endmodule : adc_conversion_scan_control_tb_top
